// ==== rtl/receiver_config_register_map.sv ====
// Upper configuration register bank reached over the serial peripheral port.
// Assumes port pins are asynchronous to clk_sys and much slower than it;
// done, tick and loop-high inputs come from logic on clk_sys.

// Behaviour
// [R1] Oscillator B count: 13 bits, low byte here, high bits from outside.
// [R2] Oscillator fast-acquire time: 14 bits over two addresses, reset four.
// [R3] Pump bit 6 enables fast acquire; bit 5 inverts polarity.
// [R4] Pump current bits 4..2 select value plus one unit steps.
// [R5] Manual pump code: 0 off, 1 up, 2 down, 3 normal; reset 3.
// [R6] Clock loop manual pump: same codes, reset 3.
// [R7] Clock reference divisor: 14 bits over two registers, reset 56.
// [R8] Clock feedback divisor: 13 bits over two registers, reset 0x3C.
// [R9] Clock fast-acquire time: 14 bits over two addresses, reset four.
// [R10] Port control A resets to 0x12, floating sync and clock pins.
// [R11] Port control B resets to 0x07.
// [R12] Output clock is sample clock over 4-bit divisor, reset one.
// [R13] Tuning bit 1 starts tank tuning; cleared when done.
// [R14] Tuning bit 0 starts RC tuning; cleared when done.
// [R15] Coarse tank cap 3 bits, fine tank cap 6 bits, reset zero.
// [R16] RC resonator capacitance: 8 bits, reset zero.
// [R17] Manual select bit drives feedback DAC from the manual value.
// [R18] Bit 3 at 0x3A enables readback; reset off. Gates only the data pin; four-wire reads reach the aux pin regardless.
// [R19] Revision is read-only; writing 0x99 resets the device.
// [R20] Host never writes factory test fields.
// [R21] Multi-byte values big endian, applied on the low byte write.
// [R22] Header: read flag, six address bits, don't-care bit.
// [R23] Float bit 3 at 0x3B releases the auxiliary output pin.
// [R24] Unused bits and addresses read zero, ignore writes.
// [R25] Overload flag bit 6 of 0x3E shows the detector state.
module receiver_config_register_map
  import receiver_config_pkg::*;
#(
  parameter logic [7:0] REVISION_ID = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Serial peripheral port pins
  input  wire logic        serialClk,
  input  wire logic        serialEnableN,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOe,
  output logic             auxSerialOutputPin,
  output logic             auxSerialOutputOe,
  // Surrounding logic
  input  wire logic [4:0]  oscLoopBCountHigh,
  input  wire logic        tankTuneDone,
  input  wire logic        rcTuneDone,
  input  wire logic        overloadDetect,
  input  wire logic        sampleClkTick,
  // Oscillator loop settings
  output logic [12:0]      osc_loop_b_count,
  output logic             osc_loop_fast_acq_en,
  output logic             osc_loop_pump_invert,
  output logic [2:0]       osc_loop_pump_current,
  output logic [1:0]       osc_loop_pump_manual,
  output logic [13:0]      osc_loop_fast_acq_time,
  // Clock loop settings
  output logic [13:0]      clk_loop_ref_divisor,
  output logic [12:0]      clk_loop_fb_divisor,
  output logic             clk_loop_fast_acq_en,
  output logic             clk_loop_pump_invert,
  output logic [2:0]       clk_loop_pump_current,
  output logic [1:0]       clk_loop_pump_manual,
  output logic [13:0]      clk_loop_fast_acq_time,
  // Output port
  output logic [7:0]       out_port_control_a,
  output logic [7:0]       out_port_control_b,
  output logic [3:0]       out_rate_divisor,
  output logic             outRateTick,
  output logic             frameSyncPinOe,
  output logic             outputClockPinOe,
  // Converter tuning and feedback
  output logic             tank_tuning_start,
  output logic             rc_tuning_start,
  output logic [2:0]       tank_coarse_cap,
  output logic [5:0]       tank_fine_cap,
  output logic [7:0]       rc_resonator_cap,
  output logic             feedbackDacManual,
  output logic [7:0]       feedbackDacValue,
  output logic             rc_quality_boost,
  output logic             rc_resonator_bypass,
  output logic             switched_cap_resonator_bypass,
  output logic             softResetPulse
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] clkSync_q;
  logic [1:0] enSync_q;
  logic [1:0] dataSync_q;
  logic [1:0] ovlSync_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      clkSync_q  <= 3'h0;
      enSync_q   <= 2'h3;
      dataSync_q <= 2'h0;
      ovlSync_q  <= 2'h0;
    end else begin
      clkSync_q  <= {clkSync_q[1:0], serialClk};
      enSync_q   <= {enSync_q[0], serialEnableN};
      dataSync_q <= {dataSync_q[0], serialDataIn};
      ovlSync_q  <= {ovlSync_q[0], overloadDetect};
    end
  end

  // Third clock stage only feeds the edge detector
  wire clkRise   = clkSync_q[1] & ~clkSync_q[2];
  wire frameIdle = enSync_q[1];
  wire dataBit   = dataSync_q[1];

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  port_state_type state_q, state_d;
  logic [2:0] bitCnt_q;
  logic [6:0] shiftIn_q;
  logic [5:0] addr_q;
  logic [7:0] shiftOut_q;
  logic [7:0] readByte;

  wire [7:0] newByte   = {shiftIn_q, dataBit};
  wire       byteDone  = clkRise && (bitCnt_q == LAST_BIT);
  wire       headerEnd = byteDone && (state_q == PORT_IDLE);
  wire       wrStrobe  = byteDone && (state_q == PORT_WRITE);  // [R21]

  always_comb begin
    state_d = state_q;
    case (state_q)
      PORT_IDLE:  if (headerEnd) state_d = newByte[7] ? PORT_READ : PORT_WRITE;  // [R22]
      PORT_WRITE: state_d = PORT_WRITE;
      PORT_READ:  state_d = PORT_READ;
      default:    state_d = PORT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= PORT_IDLE;
      bitCnt_q   <= 3'h0;
      shiftIn_q  <= 7'h00;
      addr_q     <= 6'h00;
      shiftOut_q <= 8'h00;
    end else if (frameIdle) begin
      // Enable high aborts any partial byte
      state_q    <= PORT_IDLE;
      bitCnt_q   <= 3'h0;
      shiftOut_q <= 8'h00;
    end else if (clkRise) begin
      state_q    <= state_d;
      bitCnt_q   <= bitCnt_q + 3'h1;
      shiftIn_q  <= newByte[6:0];
      if (headerEnd) begin
        addr_q <= newByte[6:1];  // [R22]
      end else if (wrStrobe) begin
        addr_q <= addr_q + 6'h01;
      end
      if (headerEnd) begin
        shiftOut_q <= readByte;
      end else begin
        shiftOut_q <= {shiftOut_q[6:0], 1'b0};
      end
    end
  end

  wire [5:0] hdrAddr = newByte[6:1];
  wire [5:0] rdAddr  = headerEnd ? hdrAddr : addr_q;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0]  loBLow_q;
  logic [6:0]  loPump_q, ckPump_q;
  logic [5:0]  loFaHigh_q, ckRefHigh_q, ckFaHigh_q;
  logic [4:0]  ckFbHigh_q;
  logic [13:0] osc_loop_fast_acq_time_q, ckRef_q, clk_loop_fast_acq_time_q;
  logic [12:0] loB_q, ckFb_q;
  logic [7:0]  ctrlA_q, ctrlB_q, rcCap_q, dacValue_q;
  logic [3:0]  rateDiv_q;
  logic [2:0]  coarse_q, bypass_q;
  logic [5:0]  fine_q;
  logic        dacSel_q, readEn_q, float_q;
  logic        tuneTank_q, tuneRc_q, softRst_q;

  function automatic logic hit(input logic [5:0] a);
    hit = wrStrobe && (addr_q == a);
  endfunction

  wire [7:0] wd = newByte;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      softRst_q <= 1'b0;
    end else begin
      softRst_q <= hit(ADDR_REVISION) && (wd == SOFT_RESET_CODE);  // [R19]
    end
  end

  // Loop synthesiser registers; high bytes are staged until the low byte
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst || softRst_q) begin  // [R19]
      loBLow_q    <= RST_LO_B[7:0];
      loB_q       <= RST_LO_B;
      loPump_q    <= RST_PUMP;  // [R5]
      loFaHigh_q  <= RST_FAST_ACQ[13:8];
      osc_loop_fast_acq_time_q      <= RST_FAST_ACQ;  // [R2]
      ckRefHigh_q <= RST_CK_REF[13:8];
      ckRef_q     <= RST_CK_REF;  // [R7]
      ckFbHigh_q  <= RST_CK_FB[12:8];
      ckFb_q      <= RST_CK_FB;  // [R8]
      ckPump_q    <= RST_PUMP;  // [R6]
      ckFaHigh_q  <= RST_FAST_ACQ[13:8];
      clk_loop_fast_acq_time_q      <= RST_FAST_ACQ;  // [R9]
    end else begin
      if (hit(ADDR_LO_B_LOW)) begin
        loBLow_q <= wd;
        loB_q    <= {oscLoopBCountHigh, wd};  // [R1] [R21]
      end
      if (hit(ADDR_LO_PUMP))     loPump_q    <= wd[6:0];
      if (hit(ADDR_LO_FA_HIGH))  loFaHigh_q  <= wd[5:0];
      if (hit(ADDR_LO_FA_LOW))   osc_loop_fast_acq_time_q      <= {loFaHigh_q, wd};  // [R2] [R21]
      if (hit(ADDR_CK_REF_HIGH)) ckRefHigh_q <= wd[5:0];
      if (hit(ADDR_CK_REF_LOW))  ckRef_q     <= {ckRefHigh_q, wd};  // [R7] [R21]
      if (hit(ADDR_CK_FB_HIGH))  ckFbHigh_q  <= wd[4:0];
      if (hit(ADDR_CK_FB_LOW))   ckFb_q      <= {ckFbHigh_q, wd};  // [R8] [R21]
      if (hit(ADDR_CK_PUMP))     ckPump_q    <= wd[6:0];
      if (hit(ADDR_CK_FA_HIGH))  ckFaHigh_q  <= wd[5:0];
      if (hit(ADDR_CK_FA_LOW))   clk_loop_fast_acq_time_q      <= {ckFaHigh_q, wd};  // [R9] [R21]
    end
  end

  // Port, converter and feedback registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst || softRst_q) begin
      ctrlA_q    <= RST_PORT_CTRL_A;  // [R10]
      ctrlB_q    <= RST_PORT_CTRL_B;  // [R11]
      rateDiv_q  <= RST_RATE_DIV;  // [R12]
      coarse_q   <= 3'h0;  // [R15]
      fine_q     <= 6'h00;  // [R15]
      rcCap_q    <= 8'h00;  // [R16]
      dacSel_q   <= 1'b0;
      dacValue_q <= 8'h00;
      readEn_q   <= 1'b0;  // [R18]
      float_q    <= 1'b0;
      bypass_q   <= 3'h0;
    end else begin
      if (hit(ADDR_PORT_CTRL_A)) ctrlA_q    <= wd;
      if (hit(ADDR_PORT_CTRL_B)) ctrlB_q    <= wd;
      if (hit(ADDR_RATE_DIV))    rateDiv_q  <= wd[3:0];
      if (hit(ADDR_TANK_COARSE)) coarse_q   <= wd[2:0];
      if (hit(ADDR_TANK_FINE))   fine_q     <= wd[5:0];
      if (hit(ADDR_RC_CAP))      rcCap_q    <= wd;
      if (hit(ADDR_DAC_SELECT))  dacSel_q   <= wd[0];
      if (hit(ADDR_DAC_VALUE))   dacValue_q <= wd;
      if (hit(ADDR_READBACK_EN)) readEn_q   <= wd[READBACK_BIT];  // [R18]
      if (hit(ADDR_AUX_FLOAT))   float_q    <= wd[FLOAT_BIT];  // [R23]
      if (hit(ADDR_OVERLOAD))    bypass_q   <= wd[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Self-clearing tuning triggers
  // ----------------------------------------------------------------
  wire tuneWrite  = hit(ADDR_TUNE_START);
  wire tankSet    = tuneWrite && wd[TUNE_TANK_BIT];
  wire rcSet      = tuneWrite && wd[RC_TUNING_START_BIT];

  // A fresh start beats a done in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst || softRst_q) begin
      tuneTank_q <= 1'b0;
      tuneRc_q   <= 1'b0;
    end else begin
      tuneTank_q <= tankSet || (tuneTank_q && !tankTuneDone);  // [R13]
      tuneRc_q   <= rcSet || (tuneRc_q && !rcTuneDone);  // [R14]
    end
  end

  // ----------------------------------------------------------------
  // Output rate divider
  // ----------------------------------------------------------------
  logic [3:0] rateCnt_q;
  logic       rateTick_q;
  // Divisor zero wraps to sixteen rather than stopping the clock
  wire        rateWrap = sampleClkTick && (rateCnt_q == (rateDiv_q - 4'h1));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rateCnt_q  <= 4'h0;
      rateTick_q <= 1'b0;
    end else begin
      rateTick_q <= rateWrap;  // [R12]
      if (rateWrap) begin
        rateCnt_q <= 4'h0;
      end else if (sampleClkTick) begin
        rateCnt_q <= rateCnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] readMux(input logic [5:0] a);
    case (a)
      ADDR_LO_B_LOW:    readMux = loB_q[7:0];
      ADDR_LO_PUMP:     readMux = {1'b0, loPump_q};
      ADDR_LO_FA_HIGH:  readMux = {2'h0, loFaHigh_q};
      ADDR_LO_FA_LOW:   readMux = osc_loop_fast_acq_time_q[7:0];
      ADDR_CK_REF_HIGH: readMux = {2'h0, ckRefHigh_q};
      ADDR_CK_REF_LOW:  readMux = ckRef_q[7:0];
      ADDR_CK_FB_HIGH:  readMux = {3'h0, ckFbHigh_q};
      ADDR_CK_FB_LOW:   readMux = ckFb_q[7:0];
      ADDR_CK_PUMP:     readMux = {1'b0, ckPump_q};
      ADDR_CK_FA_HIGH:  readMux = {2'h0, ckFaHigh_q};
      ADDR_CK_FA_LOW:   readMux = clk_loop_fast_acq_time_q[7:0];
      ADDR_PORT_CTRL_A: readMux = ctrlA_q;
      ADDR_PORT_CTRL_B: readMux = ctrlB_q;
      ADDR_RATE_DIV:    readMux = {4'h0, rateDiv_q};
      ADDR_TUNE_START:  readMux = {6'h00, tuneTank_q, tuneRc_q};
      ADDR_TANK_COARSE: readMux = {5'h00, coarse_q};
      ADDR_TANK_FINE:   readMux = {2'h0, fine_q};
      ADDR_RC_CAP:      readMux = rcCap_q;
      ADDR_DAC_SELECT:  readMux = {7'h00, dacSel_q};
      ADDR_DAC_VALUE:   readMux = dacValue_q;
      ADDR_READBACK_EN: readMux = {4'h0, readEn_q, 3'h0};
      ADDR_AUX_FLOAT:   readMux = {4'h0, float_q, 3'h0};
      ADDR_OVERLOAD:    readMux = {1'b0, ovlSync_q[1], 3'h0, bypass_q};  // [R25]
      ADDR_REVISION:    readMux = REVISION_ID;  // [R19]
      default:          readMux = 8'h00;  // [R24]
    endcase
  endfunction

  assign readByte = readMux(rdAddr);

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire fourWire  = ctrlB_q[FOUR_WIRE_BIT];
  wire reading   = (state_q == PORT_READ) && !frameIdle;

  assign serialDataOut      = shiftOut_q[7];
  assign serialDataOe       = reading && readEn_q && !fourWire;  // [R18]
  assign auxSerialOutputPin = fourWire && reading && shiftOut_q[7];
  assign auxSerialOutputOe  = !float_q;  // [R23]

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  assign osc_loop_b_count       = loB_q;  // [R1]
  assign osc_loop_fast_acq_en   = loPump_q[PUMP_FAST_BIT];  // [R3]
  assign osc_loop_pump_invert   = loPump_q[PUMP_INVERT_BIT];  // [R3]
  assign osc_loop_pump_current  = loPump_q[4:2];  // [R4]
  assign osc_loop_pump_manual   = loPump_q[1:0];  // [R5]
  assign osc_loop_fast_acq_time = osc_loop_fast_acq_time_q;
  assign clk_loop_ref_divisor   = ckRef_q;
  assign clk_loop_fb_divisor    = ckFb_q;
  assign clk_loop_fast_acq_en   = ckPump_q[PUMP_FAST_BIT];  // [R3]
  assign clk_loop_pump_invert   = ckPump_q[PUMP_INVERT_BIT];  // [R3]
  assign clk_loop_pump_current  = ckPump_q[4:2];  // [R4]
  assign clk_loop_pump_manual   = ckPump_q[1:0];  // [R6]
  assign clk_loop_fast_acq_time = clk_loop_fast_acq_time_q;

  assign out_port_control_a = ctrlA_q;
  assign out_port_control_b = ctrlB_q;  // [R11]
  assign out_rate_divisor   = rateDiv_q;
  assign outRateTick        = rateTick_q;
  assign frameSyncPinOe     = !ctrlA_q[PINS_FLOAT_BIT];  // [R10]
  assign outputClockPinOe   = !ctrlA_q[PINS_FLOAT_BIT];  // [R10]

  assign tank_tuning_start             = tuneTank_q;
  assign rc_tuning_start               = tuneRc_q;
  assign tank_coarse_cap               = coarse_q;
  assign tank_fine_cap                 = fine_q;
  assign rc_resonator_cap              = rcCap_q;
  assign feedbackDacManual             = dacSel_q;  // [R17]
  assign feedbackDacValue              = dacValue_q;  // [R17]
  assign rc_quality_boost              = bypass_q[2];
  assign rc_resonator_bypass           = bypass_q[1];
  assign switched_cap_resonator_bypass = bypass_q[0];
  assign softResetPulse                = softRst_q;  // [R19]

endmodule

// ==== shared/receiver_config_pkg.sv ====
// Constants of the upper receiver configuration register bank.
// Assumes one 25 MHz system clock and the serial peripheral port pins.
package receiver_config_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_LO_B_LOW      = 6'h0B;
  localparam logic [5:0] ADDR_LO_PUMP       = 6'h0C;
  localparam logic [5:0] ADDR_LO_FA_HIGH    = 6'h0D;
  localparam logic [5:0] ADDR_LO_FA_LOW     = 6'h0E;
  localparam logic [5:0] ADDR_CK_REF_HIGH   = 6'h10;
  localparam logic [5:0] ADDR_CK_REF_LOW    = 6'h11;
  localparam logic [5:0] ADDR_CK_FB_HIGH    = 6'h12;
  localparam logic [5:0] ADDR_CK_FB_LOW     = 6'h13;
  localparam logic [5:0] ADDR_CK_PUMP       = 6'h14;
  localparam logic [5:0] ADDR_CK_FA_HIGH    = 6'h15;
  localparam logic [5:0] ADDR_CK_FA_LOW     = 6'h16;
  localparam logic [5:0] ADDR_PORT_CTRL_A   = 6'h18;
  localparam logic [5:0] ADDR_PORT_CTRL_B   = 6'h19;
  localparam logic [5:0] ADDR_RATE_DIV      = 6'h1A;
  localparam logic [5:0] ADDR_TUNE_START    = 6'h1C;
  localparam logic [5:0] ADDR_TANK_COARSE   = 6'h1D;
  localparam logic [5:0] ADDR_TANK_FINE     = 6'h1E;
  localparam logic [5:0] ADDR_RC_CAP        = 6'h1F;
  localparam logic [5:0] ADDR_DAC_SELECT    = 6'h38;
  localparam logic [5:0] ADDR_DAC_VALUE     = 6'h39;
  localparam logic [5:0] ADDR_READBACK_EN   = 6'h3A;
  localparam logic [5:0] ADDR_AUX_FLOAT     = 6'h3B;
  localparam logic [5:0] ADDR_OVERLOAD      = 6'h3E;
  localparam logic [5:0] ADDR_REVISION      = 6'h3F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [12:0] RST_LO_B          = 13'h001D;
  localparam logic [6:0]  RST_PUMP          = 7'h03;
  localparam logic [13:0] RST_FAST_ACQ      = 14'h0004;
  localparam logic [13:0] RST_CK_REF        = 14'h0038;
  localparam logic [12:0] RST_CK_FB         = 13'h003C;
  localparam logic [7:0]  RST_PORT_CTRL_A   = 8'h12;
  localparam logic [7:0]  RST_PORT_CTRL_B   = 8'h07;
  localparam logic [3:0]  RST_RATE_DIV      = 4'h1;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int          PUMP_FAST_BIT     = 6;
  localparam int          PUMP_INVERT_BIT   = 5;
  localparam int          TUNE_TANK_BIT     = 1;
  localparam int          RC_TUNING_START_BIT       = 0;
  localparam int          READBACK_BIT      = 3;
  localparam int          FLOAT_BIT         = 3;
  localparam int          OVERLOAD_BIT      = 6;
  localparam int          FOUR_WIRE_BIT     = 7;
  localparam int          PINS_FLOAT_BIT    = 1;
  localparam logic [7:0]  SOFT_RESET_CODE   = 8'h99;
  localparam logic [1:0]  MANUAL_OFF        = 2'h0;
  localparam logic [1:0]  MANUAL_UP         = 2'h1;
  localparam logic [1:0]  MANUAL_DOWN       = 2'h2;
  localparam logic [1:0]  MANUAL_NORMAL     = 2'h3;
  localparam logic [2:0]  LAST_BIT          = 3'h7;

  typedef enum logic [2:0] {
    PORT_IDLE   = 3'b001,
    PORT_WRITE  = 3'b010,
    PORT_READ   = 3'b100
  } port_state_type;

endpackage

// ==== verif/receiver_config_register_map_properties.sv ====
// Port-level checks of the upper receiver register bank.
// Assumes it is bound into receiver_config_register_map on clk_sys.
module receiver_config_register_map_properties
  import receiver_config_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Pins
  input wire logic        serialDataOe,
  input wire logic        frameSyncPinOe,
  input wire logic        outputClockPinOe,
  // Events
  input wire logic        outRateTick,
  input wire logic        sampleClkTick,
  input wire logic        softResetPulse,
  input wire logic        tank_tuning_start,
  input wire logic        rc_tuning_start,
  input wire logic        tankTuneDone,
  input wire logic        rcTuneDone,
  // Fields
  input wire logic [7:0]  out_port_control_a,
  input wire logic [7:0]  out_port_control_b,
  input wire logic [3:0]  out_rate_divisor,
  input wire logic [1:0]  osc_loop_pump_manual,
  input wire logic [1:0]  clk_loop_pump_manual,
  input wire logic [13:0] clk_loop_ref_divisor
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_port_reset : assert property ($fell(sys_rst) |->
    out_port_control_a == RST_PORT_CTRL_A && out_port_control_b == RST_PORT_CTRL_B) else $error("port ctrl reset");
  a_pump_reset : assert property ($fell(sys_rst) |->
    osc_loop_pump_manual == MANUAL_NORMAL && clk_loop_pump_manual == MANUAL_NORMAL) else $error("pump reset");
  a_ref_reset : assert property ($fell(sys_rst) |-> clk_loop_ref_divisor == RST_CK_REF)
    else $error("ref divisor reset");
  a_pin_float : assert property (frameSyncPinOe == !out_port_control_a[PINS_FLOAT_BIT]
    && outputClockPinOe == frameSyncPinOe) else $error("pin float");
  // Two edges allowed: the bank reloads on the same edge that samples the pulse
  a_soft_restore : assert property (softResetPulse |-> ##2
    out_rate_divisor == RST_RATE_DIV && out_port_control_a == RST_PORT_CTRL_A) else $error("soft reset");
  a_tank_hold : assert property (tank_tuning_start && !tankTuneDone && !softResetPulse
    && !$past(softResetPulse) |=> tank_tuning_start) else $error("tank start dropped");
  a_rc_hold : assert property (rc_tuning_start && !rcTuneDone && !softResetPulse
    && !$past(softResetPulse) |=> rc_tuning_start) else $error("rc start dropped");
  a_tick_cause : assert property (outRateTick |-> $past(sampleClkTick)) else $error("stray tick");
  a_readback_mode : assert property (serialDataOe |-> !out_port_control_b[FOUR_WIRE_BIT])
    else $error("data pin driven in 4-wire");

  c_soft : cover property (softResetPulse);
  c_tick : cover property (outRateTick);
  c_read : cover property (serialDataOe);
endmodule

bind receiver_config_register_map receiver_config_register_map_properties chk_u (.*);

// ==== verif/receiver_config_register_map_tb.sv ====
// Self-checking bench for the upper receiver register bank.
// Assumes serial clock phases of four system clocks; commit lag below six.
`define CHECK_EQ(nm, gt, ex) begin cmpCount++; if ((gt) !== (ex)) begin \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); errCount++; end end

module receiver_config_register_map_tb import receiver_config_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] REV = 8'hC4;  // Arbitrary value
  logic        clk_sys, sys_rst, serialClk, serialEnableN, serialDataIn, tankTuneDone, rcTuneDone;
  logic        overloadDetect, sampleClkTick, serialDataOut, serialDataOe, auxSerialOutputOe, outRateTick;
  logic        frameSyncPinOe, outputClockPinOe, tank_tuning_start, rc_tuning_start, feedbackDacManual;
  logic        softResetPulse, osc_loop_fast_acq_en, osc_loop_pump_invert, clk_loop_fast_acq_en;
  logic        clk_loop_pump_invert, auxSerialOutputPin, rc_quality_boost, rc_resonator_bypass;
  logic        switched_cap_resonator_bypass;
  logic [1:0]  osc_loop_pump_manual, clk_loop_pump_manual;
  logic [2:0]  osc_loop_pump_current, clk_loop_pump_current, tank_coarse_cap;
  logic [3:0]  out_rate_divisor;
  logic [4:0]  oscLoopBCountHigh;
  logic [5:0]  tank_fine_cap;
  logic [7:0]  out_port_control_a, out_port_control_b, rc_resonator_cap, feedbackDacValue;
  logic [12:0] osc_loop_b_count, clk_loop_fb_divisor;
  logic [13:0] osc_loop_fast_acq_time, clk_loop_ref_divisor, clk_loop_fast_acq_time;
  int          errCount, cmpCount, ticks;

  receiver_config_register_map #(.REVISION_ID(REV)) dut_u (.*);

  // ----------------------------------------------------------------
  // Port tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Read bit sampled late in the low phase, after the sync lag
  task automatic shift(input logic [7:0] v, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      serialDataIn = v[i];
      cyc(4);
      q[i] = serialDataOut;
      serialClk = 1'b1;
      cyc(4);
      serialClk = 1'b0;
    end
  endtask

  task automatic xfer(input logic rdn, input logic [5:0] a, input logic [15:0] d, input logic two,
                      output logic [7:0] q);
    serialEnableN = 1'b0;
    cyc(4);
    shift({rdn, a, 1'b0}, q);
    shift(d[15:8], q);
    if (two) shift(d[7:0], q);
    serialEnableN = 1'b1;
    cyc(6);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, {d, 8'h00}, 1'b0, q);
  endtask

  task automatic wr2(input logic [5:0] a, input logic [15:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, 1'b1, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] ex);
    logic [7:0] q;
    xfer(1'b1, a, 16'h0000, 1'b0, q);
    `CHECK_EQ("register read", q, ex)
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask

  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    cyc(60000);
    errCount++;
    finishTest;
  end

  initial begin
    sys_rst = 1'b1;
    {serialClk, serialDataIn, tankTuneDone, rcTuneDone, overloadDetect, sampleClkTick} = 6'h00;
    serialEnableN = 1'b1;
    oscLoopBCountHigh = 5'h15;
    cyc(10);
    sys_rst = 1'b0;
    cyc(6);
    `CHECK_EQ("ctrl a, pin oe", {out_port_control_a, frameSyncPinOe}, 9'h024)
    `CHECK_EQ("ctrl b", out_port_control_b, 8'h07)
    `CHECK_EQ("rate divisor", out_rate_divisor, 4'h1)
    `CHECK_EQ("b count", osc_loop_b_count, 13'h001D)
    `CHECK_EQ("osc fast acq", osc_loop_fast_acq_time, 14'h0004)
    `CHECK_EQ("pump codes", {osc_loop_pump_manual, clk_loop_pump_manual}, 4'hF)
    `CHECK_EQ("fb divisor", clk_loop_fb_divisor, 13'h003C)
    `CHECK_EQ("clk fast acq", clk_loop_fast_acq_time, 14'h0004)
    `CHECK_EQ("caps", {tank_coarse_cap, tank_fine_cap, rc_resonator_cap}, 17'h00000)
    `CHECK_EQ("pin enables", {serialDataOe, auxSerialOutputOe}, 2'b01)
    wr(6'h3A, 8'h08);
    rd(6'h3A, 8'h08);
    wr(6'h10, 8'hFF);
    `CHECK_EQ("ref staged", clk_loop_ref_divisor, 14'h0038)
    rd(6'h10, 8'h3F);
    wr(6'h11, 8'hFF);
    `CHECK_EQ("ref divisor", clk_loop_ref_divisor, 14'h3FFF)
    wr2(6'h12, 16'hFF03);
    `CHECK_EQ("fb divisor", clk_loop_fb_divisor, 13'h1F03)
    wr2(6'h0D, 16'hEA55);
    `CHECK_EQ("osc fast acq", osc_loop_fast_acq_time, 14'h2A55)
    wr2(6'h15, 16'h0102);
    `CHECK_EQ("clk fast acq", clk_loop_fast_acq_time, 14'h0102)
    wr(6'h0B, 8'hC3);
    `CHECK_EQ("b count", osc_loop_b_count, 13'h15C3)
    for (int m = 0; m < 4; m++) begin
      wr(6'h0C, 8'h54 | 8'(m));
      wr(6'h14, 8'h2C | 8'(m));
      `CHECK_EQ("osc pump", {osc_loop_fast_acq_en, osc_loop_pump_invert, osc_loop_pump_current, osc_loop_pump_manual}, 7'h54 | 7'(m))
      `CHECK_EQ("clk pump", {clk_loop_fast_acq_en, clk_loop_pump_invert, clk_loop_pump_current, clk_loop_pump_manual}, 7'h2C | 7'(m))
    end
    wr(6'h1A, 8'hF3);
    `CHECK_EQ("rate divisor", out_rate_divisor, 4'h3)
    repeat (12) begin
      sampleClkTick = 1'b1;
      cyc(1);
      ticks += int'(outRateTick);
      sampleClkTick = 1'b0;
      cyc(1);
      ticks += int'(outRateTick);
    end
    `CHECK_EQ("rate ticks", ticks, 4)
    wr(6'h1C, 8'h03);
    `CHECK_EQ("tuning", {tank_tuning_start, rc_tuning_start}, 2'b11)
    rd(6'h1C, 8'h03);
    pulse(tankTuneDone);
    `CHECK_EQ("tuning", {tank_tuning_start, rc_tuning_start}, 2'b01)
    pulse(rcTuneDone);
    `CHECK_EQ("tuning", {tank_tuning_start, rc_tuning_start}, 2'b00)
    wr(6'h1D, 8'hFF);
    wr(6'h1E, 8'hFF);
    wr(6'h1F, 8'hA5);
    `CHECK_EQ("caps", {tank_coarse_cap, tank_fine_cap, rc_resonator_cap}, 17'h1FFA5)
    wr(6'h39, 8'h5A);
    wr(6'h38, 8'h01);
    `CHECK_EQ("dac", {feedbackDacManual, feedbackDacValue}, 9'h15A)
    rd(6'h38, 8'h01);
    wr(6'h17, 8'hFF);
    rd(6'h17, 8'h00);
    overloadDetect = 1'b1;
    rd(6'h3E, 8'h40);
    wr(6'h3F, 8'h12);
    rd(6'h3F, REV);
    wr(6'h18, 8'h10);
    `CHECK_EQ("pin oe", {frameSyncPinOe, outputClockPinOe}, 2'b11)
    wr(6'h3B, 8'h08);
    `CHECK_EQ("aux oe", auxSerialOutputOe, 1'b0)
    wr(6'h3F, 8'h99);
    cyc(3);
    `CHECK_EQ("soft reset", {out_port_control_a, out_rate_divisor, clk_loop_ref_divisor}, 26'h0484038)
    finishTest;
  end
endmodule
